// File: logic/mpp_pkg.sv
// What this block does
// - First port: eight bidirectional lines, each with its own pull-up select.
// - Second port: seven lines with pull-ups; top line doubles as reset input.
// - Third port: eight bidirectional lines, each with its own pull-up select.
// - Any active reset puts every pin of all ports in high impedance.
// - Clock fuses may give first port bit six to the oscillator amplifier.
// - Clock fuses may give first port bit seven to the oscillator amplifier.
// - RC clock plus async timer select turns bits seven, six into timer pins.
// - Reset disable fuse unprogrammed: top second-port line is active-low reset.
// - Reset line low beyond minimum pulse length causes a device reset.
//
// Purpose: constants and types for the port pin block
// Assumes: 100 MHz aclk, AXI4-Lite register access
// Notes: first port is index 0, second 1, third 2

package mpp_pkg;

	localparam int NPORT = 3;
	localparam int PW = 8;
	localparam logic [2:0][7:0] PORT_MASK = {8'hff, 8'h7f, 8'hff};
	localparam int RST_LINE_PORT = 1;
	localparam int RST_LINE_BIT = 6;
	localparam int XTAL_IN_BIT = 6;
	localparam int XTAL_OUT_BIT = 7;

	localparam int ADDR_W = 6;
	localparam logic [5:0] REG_DIR0 = 6'h00;
	localparam logic [5:0] REG_OUT0 = 6'h04;
	localparam logic [5:0] REG_IN0 = 6'h08;
	localparam logic [5:0] REG_STRIDE = 6'h0c;
	localparam logic [5:0] REG_CTRL = 6'h24;
	localparam logic [5:0] REG_STAT = 6'h28;
	localparam logic [5:0] REG_LAST = 6'h28;

	localparam int CTRL_TSEL = 0;
	localparam int STAT_PINRST = 0;
	localparam int STAT_RSTDIS = 1;
	localparam int STAT_XTAL = 2;
	localparam int STAT_RCSEL = 4;

	localparam logic [1:0] XT_NONE = 2'h0;
	localparam logic [1:0] XT_EXT = 2'h1;
	localparam logic [1:0] XT_FULL = 2'h2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] OUT_RST = 8'h00;
	localparam logic [7:0] IN_RST = 8'hff;

	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_MIN_PULSE_NS = 2500;
	localparam int RST_HOLD_NS = 1000;
	localparam int RST_MIN_CYC =
		(RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_HOLD_CYC =
		(RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 12;

	typedef enum logic [1:0] {RS_IDLE, RS_LOW, RS_HOLD} mpp_rst_e;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
		logic [7:0] pu;
	} mpp_pad_s;

endpackage

// File: logic/mpp_ports.sv
// Purpose: three GPIO ports, oscillator pin reuse, filtered reset pin
// Assumes: fuses are static and are caught while aresetn is low
// Notes: pads are three signals each; the bench resolves the wire
`timescale 1ns/1ps
`default_nettype none

module mpp_ports
	import mpp_pkg::*;
#(
	parameter int unsigned MIN_CYC = RST_MIN_CYC,
	parameter int unsigned HOLD_CYC = RST_HOLD_CYC
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0][7:0] pad_in,
	output mpp_pad_s [2:0] pad,
	input wire logic reset_pin_disable_fuse,
	input wire logic [1:0] xtal_fuse_mode,
	input wire logic rc_clock_selected,
	output logic crystal_amp_input,
	output logic crystal_amp_output,
	output logic timer_osc_active,
	output logic device_reset_n
);

	logic rstdis_q;
	logic [1:0] xtal_q;
	logic rcsel_q;
	logic tsel_q;
	logic pinrst_q;
	logic [2:0][7:0] dir_q;
	logic [2:0][7:0] out_q;
	logic [2:0][7:0] s1_q;
	logic [2:0][7:0] s2_q;
	logic [2:0][7:0] s3_q;
	logic [2:0][7:0] in_q;
	logic [2:0][7:0] claim;
	mpp_rst_e rst_state_q;
	logic [CNT_W-1:0] rst_cnt_q;
	logic rst_en;
	logic any_rst;
	logic aw_full_q;
	logic w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_wr;
	logic [31:0] rd_d;

	// Fuses are straps: sampled by the clock while reset is held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rstdis_q <= reset_pin_disable_fuse;
			xtal_q <= xtal_fuse_mode;
			rcsel_q <= rc_clock_selected;
		end
	end

	assign rst_en = ~rstdis_q;

	// Pin inputs: three stages, a bit changes once stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			in_q <= {NPORT{IN_RST}};
		end
		else
		begin
			s1_q <= pad_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			in_q <= ((s2_q ^ s3_q) & in_q) | (~(s2_q ^ s3_q) & s3_q);
		end
	end

	// Reset pin filter: low must last MIN_CYC cycles, then reset holds
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rst_state_q <= RS_IDLE;
			rst_cnt_q <= '0;
			device_reset_n <= 1'b1;
		end
		else
		begin
			case (rst_state_q)
				RS_IDLE:
				begin
					if (rst_en && !in_q[RST_LINE_PORT][RST_LINE_BIT])
					begin
						rst_state_q <= RS_LOW;
						rst_cnt_q <= '0;
					end
				end
				RS_LOW:
				begin
					if (in_q[RST_LINE_PORT][RST_LINE_BIT] || !rst_en)
						rst_state_q <= RS_IDLE;
					else if (rst_cnt_q >= CNT_W'(MIN_CYC - 1))
					begin
						rst_state_q <= RS_HOLD;
						rst_cnt_q <= '0;
						device_reset_n <= 1'b0;
					end
					else
						rst_cnt_q <= rst_cnt_q + 1'b1;
				end
				RS_HOLD:
				begin
					// Hold time restarts while the line is still low
					if (!in_q[RST_LINE_PORT][RST_LINE_BIT])
						rst_cnt_q <= '0;
					else if (rst_cnt_q >= CNT_W'(HOLD_CYC - 1))
					begin
						rst_state_q <= RS_IDLE;
						device_reset_n <= 1'b1;
					end
					else
						rst_cnt_q <= rst_cnt_q + 1'b1;
				end
				default:
				begin
					rst_state_q <= RS_IDLE;
					device_reset_n <= 1'b1;
				end
			endcase
		end
	end

	// Raw reset level gates the pads so tristate needs no clock edge
	assign any_rst = ~aresetn | ~device_reset_n
		| (rst_en & ~pad_in[RST_LINE_PORT][RST_LINE_BIT]);

	// Oscillator claims on first port bits six and seven, reset line claim on second port bit six
	always_comb
	begin
		claim = '0;
		timer_osc_active = rcsel_q & tsel_q;
		crystal_amp_input = ~timer_osc_active & (xtal_q != XT_NONE);
		crystal_amp_output = ~timer_osc_active & (xtal_q == XT_FULL);
		claim[0][XTAL_IN_BIT] = crystal_amp_input | timer_osc_active;
		claim[0][XTAL_OUT_BIT] = crystal_amp_output | timer_osc_active;
		claim[RST_LINE_PORT][RST_LINE_BIT] = rst_en;
	end

	// Pull-up is on for an input bit whose output latch is one
	genvar gp;
	generate
		for (gp = 0; gp < NPORT; gp++)
		begin : g_port
			logic [7:0] use_m;
			assign use_m = PORT_MASK[gp] & ~claim[gp];
			assign pad[gp].o = out_q[gp] & use_m;
			assign pad[gp].oe = any_rst ? 8'h00 : (dir_q[gp] & use_m);
			assign pad[gp].pu = any_rst ? 8'h00 : (~dir_q[gp] & out_q[gp] & use_m);
		end
	endgenerate

	// AXI4-Lite write: address and data taken in either order
	assign s_axi_awready = ~aw_full_q;
	assign s_axi_wready = ~w_full_q;
	assign do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_q)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q)
			begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_q > REG_LAST || aw_addr_q[1:0] != 2'h0)
					? RESP_SLVERR : RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Port registers; only byte lane 0 carries data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dir_q <= {NPORT{DIR_RST}};
			out_q <= {NPORT{OUT_RST}};
			tsel_q <= 1'b0;
		end
		else if (do_wr && w_strb_q[0])
		begin
			for (int p = 0; p < NPORT; p++)
			begin
				if (aw_addr_q == REG_DIR0 + ADDR_W'(p) * REG_STRIDE)
					dir_q[p] <= w_data_q[7:0] & PORT_MASK[p];
				if (aw_addr_q == REG_OUT0 + ADDR_W'(p) * REG_STRIDE)
					out_q[p] <= w_data_q[7:0] & PORT_MASK[p];
			end
			if (aw_addr_q == REG_CTRL)
				tsel_q <= w_data_q[CTRL_TSEL];
		end
	end

	// Pin reset flag: set wins over a write-one clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pinrst_q <= 1'b0;
		else if (rst_state_q == RS_LOW && !device_reset_n == 1'b0
			&& rst_cnt_q >= CNT_W'(MIN_CYC - 1)
			&& !in_q[RST_LINE_PORT][RST_LINE_BIT] && rst_en)
			pinrst_q <= 1'b1;
		else if (do_wr && w_strb_q[0] && aw_addr_q == REG_STAT
			&& w_data_q[STAT_PINRST])
			pinrst_q <= 1'b0;
	end

	// Read mux
	always_comb
	begin
		rd_d = '0;
		for (int p = 0; p < NPORT; p++)
		begin
			if (s_axi_araddr == REG_DIR0 + ADDR_W'(p) * REG_STRIDE)
				rd_d[7:0] = dir_q[p];
			if (s_axi_araddr == REG_OUT0 + ADDR_W'(p) * REG_STRIDE)
				rd_d[7:0] = out_q[p];
			if (s_axi_araddr == REG_IN0 + ADDR_W'(p) * REG_STRIDE)
				rd_d[7:0] = in_q[p] & PORT_MASK[p] & ~claim[p];
		end
		if (s_axi_araddr == REG_CTRL)
			rd_d[CTRL_TSEL] = tsel_q;
		if (s_axi_araddr == REG_STAT)
		begin
			rd_d[STAT_PINRST] = pinrst_q;
			rd_d[STAT_RSTDIS] = rstdis_q;
			rd_d[STAT_XTAL +: 2] = xtal_q;
			rd_d[STAT_RCSEL] = rcsel_q;
		end
	end

	// One read in flight; a new address waits until rvalid is taken
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_d;
			s_axi_rresp <= (s_axi_araddr > REG_LAST || s_axi_araddr[1:0] != 2'h0)
				? RESP_SLVERR : RESP_OKAY;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // mpp_ports

`default_nettype wire

// File: logic/mpp_unused_placeholder_never.sv
`timescale 1ns/1ps

// File: test/mpp_board.sv
// Purpose: board circuitry on the three ports
// Assumes: bench never drives a pin the block drives
// Notes: block drive wins, then board, then pull-up
`timescale 1ns/1ps
`default_nettype none
module mpp_board
	import mpp_pkg::*;
(
	input wire logic aclk,
	input wire mpp_pad_s [2:0] pad,
	input wire logic [2:0][7:0] ext_en,
	input wire logic [2:0][7:0] ext_val,
	output logic [2:0][7:0] pad_in
);
	logic tog_q = 1'b0;
	always @(posedge aclk)
	begin
		tog_q <= !tog_q;
	end
	// Floating lines wander so a stale level never passes for data
	always_comb
	begin
		for (int p = 0; p < 3; p++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				if (pad[p].oe[b]) pad_in[p][b] = pad[p].o[b];
				else if (ext_en[p][b]) pad_in[p][b] = ext_val[p][b];
				else if (pad[p].pu[b]) pad_in[p][b] = 1'b1;
				else pad_in[p][b] = tog_q;
			end
		end
	end
endmodule // mpp_board
`default_nettype wire

// File: test/mpp_ports_sva.sv
// Purpose: pin and reset-line checks on mpp_ports
// Assumes: fuse straps held still between resets
// Notes: bound at the foot
`timescale 1ns/1ps
`default_nettype none
module mpp_chk
	import mpp_pkg::*;
#(
	parameter int unsigned MIN_CYC = 4,
	parameter int unsigned HOLD_CYC = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0][7:0] pad_in,
	input wire mpp_pad_s [2:0] pad,
	input wire logic reset_pin_disable_fuse,
	input wire logic [1:0] xtal_fuse_mode,
	input wire logic rc_clock_selected,
	input wire logic timer_osc_active,
	input wire logic device_reset_n
);
	logic [11:0] lo_q, hi_q;
	// Raw pin run lengths, saturating so long idles never wrap
	always_ff @(posedge aclk)
	begin
		if (!aresetn || pad_in[1][6]) lo_q <= 12'h000;
		else if (lo_q != 12'hfff) lo_q <= lo_q + 12'h001;
		if (!aresetn || !pad_in[1][6]) hi_q <= 12'h000;
		else if (hi_q != 12'hfff) hi_q <= hi_q + 12'h001;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_hiz;
		!reset_pin_disable_fuse && !pad_in[1][6]
		|-> {pad[0][15:0], pad[1][15:0], pad[2][15:0]} == 48'h0;
	endproperty
	a_hiz: assert property (p_hiz) else $error("pad on in reset");
	property p_top;
		pad[1].o[7] == 1'b0 && pad[1].oe[7] == 1'b0 && pad[1].pu[7] == 1'b0;
	endproperty
	a_top: assert property (p_top) else $error("eighth line used");
	property p_x6;
		xtal_fuse_mode != XT_NONE |-> !pad[0].oe[6] && !pad[0].pu[6];
	endproperty
	a_x6: assert property (p_x6) else $error("bit six not freed");
	property p_x7;
		xtal_fuse_mode == XT_FULL |-> !pad[0].oe[7] && !pad[0].pu[7];
	endproperty
	a_x7: assert property (p_x7) else $error("bit seven not freed");
	property p_tos;
		timer_osc_active |-> rc_clock_selected && pad[0].oe[7:6] == 2'h0;
	endproperty
	a_tos: assert property (p_tos) else $error("timer pins wrong");
	property p_rl;
		!reset_pin_disable_fuse |-> !pad[1].oe[6] && !pad[1].pu[6];
	endproperty
	a_rl: assert property (p_rl) else $error("reset line driven");
	property p_go;
		$fell(device_reset_n) |-> lo_q >= MIN_CYC;
	endproperty
	a_go: assert property (p_go) else $error("reset too early");
	property p_long;
		!reset_pin_disable_fuse && lo_q == MIN_CYC + 6 |-> !device_reset_n;
	endproperty
	a_long: assert property (p_long) else $error("reset missed");
	property p_hold;
		$rose(device_reset_n) |-> hi_q >= HOLD_CYC;
	endproperty
	a_hold: assert property (p_hold) else $error("reset cut short");
	property p_dhiz;
		!device_reset_n
		|-> {pad[0][15:0], pad[1][15:0], pad[2][15:0]} == 48'h0;
	endproperty
	a_dhiz: assert property (p_dhiz) else $error("pad on in pin reset");
	c_rst: cover property ($fell(device_reset_n));
	c_tosc: cover property (timer_osc_active);
	c_full: cover property (xtal_fuse_mode == XT_FULL);
	c_back: cover property ($rose(device_reset_n));
endmodule // mpp_chk
bind mpp_ports mpp_chk #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC)) mpp_chk_inst
	(.aclk, .aresetn, .pad_in, .pad, .reset_pin_disable_fuse,
	.xtal_fuse_mode, .rc_clock_selected, .timer_osc_active, .device_reset_n);
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench for mpp_ports
// Assumes: filter counts shortened to four cycles
// Notes: board model resolves every pad
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mpp_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic reset_pin_disable_fuse = 1'b1, rc_clock_selected = 1'b0;
	logic [1:0] xtal_fuse_mode = 2'h0;
	logic [2:0][7:0] ext_en = 24'h0, ext_val = 24'h0, pad_in;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, crystal_amp_input, crystal_amp_output;
	logic timer_osc_active, device_reset_n;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata;
	mpp_pad_s [2:0] pad;
	int num_errors = 0, total_checks = 0;
	mpp_ports #(.MIN_CYC(4), .HOLD_CYC(4)) mpp_ports_inst (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pad_in, .pad, .reset_pin_disable_fuse,
		.xtal_fuse_mode, .rc_clock_selected, .crystal_amp_input,
		.crystal_amp_output, .timer_osc_active, .device_reset_n);
	mpp_board mpp_board_inst (.aclk, .pad, .ext_en, .ext_val, .pad_in);
	always #5 aclk = !aclk;
	task automatic results(input int hung);
		num_errors += hung;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [71:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
		if (i == 50) results(1);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		resp = s_axi_rresp;
		if (i == 50) results(1);
	endtask
	task automatic rst(input logic dis, input logic [1:0] xm, input logic rc);
		@(posedge aclk);
		aresetn <= 1'b0;
		reset_pin_disable_fuse <= dis;
		xtal_fuse_mode <= xm;
		rc_clock_selected <= rc;
		repeat (4) @(posedge aclk);
		chk("hiz", 72'h0, pad & {3{24'h00ffff}});
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic t_gpio();
		logic [31:0] d;
		logic [5:0] b;
		for (int p = 0; p < 3; p++)
		begin
			b = 6'(REG_STRIDE * p);
			wr(b + REG_DIR0, 8'hff);
			wr(b + REG_OUT0, 8'ha5);
			chk("drv", {8'ha5, 8'hff, 8'h00} & {3{PORT_MASK[p]}}, pad[p]);
			wr(b + REG_DIR0, 8'h00);
			wr(b + REG_OUT0, 8'hff);
			chk("pull", {8'h00, PORT_MASK[p]}, pad[p][15:0]);
			ext_en[p] <= 8'hff;
			ext_val[p] <= 8'h3c;
			repeat (5) @(posedge aclk);
			rd(b + REG_IN0, d);
			chk("in", 8'h3c & PORT_MASK[p], d);
			ext_en[p] <= 8'h00;
		end
		rd(6'h2c, d);
		chk("resp", RESP_SLVERR, resp);
	endtask
	task automatic t_claim();
		logic [7:0] e [4] = '{8'hff, 8'hbf, 8'h3f, 8'h3f};
		logic [31:0] d;
		for (int m = 0; m < 4; m++)
		begin
			rst(1'b1, m == 3 ? XT_NONE : 2'(m), m == 3);
			wr(REG_CTRL, 8'h01);
			wr(REG_DIR0, 8'hff);
			chk("claim", e[m], pad[0].oe);
			chk("tosc", m == 3, timer_osc_active);
			chk("xin", m == 1 || m == 2, crystal_amp_input);
			chk("xout", m == 2, crystal_amp_output);
			chk("bresp", RESP_OKAY, resp);
			rd(REG_CTRL, d);
			chk("ctrl", 32'h1, d);
			rd(REG_STAT, d);
			// Straps read back as captured while reset was held
			chk("fuse", (m == 3 ? 32'h1 << STAT_RCSEL : 32'(m) << STAT_XTAL)
				| 32'h1 << STAT_RSTDIS, d & 32'h1f);
		end
	endtask
	task automatic t_pin();
		logic [31:0] d;
		ext_en[1][6] <= 1'b1;
		ext_val[1][6] <= 1'b1;
		rst(1'b0, XT_NONE, 1'b0);
		wr(REG_DIR0 + REG_STRIDE, 8'h7f);
		chk("rline", 8'h3f, pad[1].oe);
		// Two-cycle pulse stays under the filter length
		ext_val[1][6] <= 1'b0;
		@(posedge aclk);
		chk("pinhiz", 72'h0, pad & {3{24'h00ffff}});
		@(posedge aclk);
		ext_val[1][6] <= 1'b1;
		repeat (10) @(posedge aclk);
		chk("short", 1'b1, device_reset_n);
		ext_val[1][6] <= 1'b0;
		repeat (12) @(posedge aclk);
		chk("long", 1'b0, device_reset_n);
		ext_val[1][6] <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("hold", 1'b0, device_reset_n);
		// Pin is high again here, so only the held reset keeps pads off
		chk("holdhiz", 72'h0, pad & {3{24'h00ffff}});
		repeat (12) @(posedge aclk);
		chk("back", 1'b1, device_reset_n);
		rd(REG_STAT, d);
		chk("flag", 32'h1, d & 32'h3);
		wr(REG_STAT, 8'h01);
		chk("wresp", RESP_OKAY, resp);
		rd(REG_STAT, d);
		chk("clear", 32'h0, d & 32'h1);
	endtask
	initial
	begin
		rst(1'b1, XT_NONE, 1'b0);
		t_gpio();
		$display("gpio test done");
		t_claim();
		$display("claim test done");
		t_pin();
		$display("pin test done");
		results(0);
	end
endmodule // testbench
`default_nettype wire
